// *** verilog/pcf_pkg.sv ***
// Purpose: constants for the position command filter and in-position block
// Assumes: 125 MHz pclk, millisecond time base derived from it
// Notes: register word offsets are byte addresses on APB
// Functional notes
// - filter acts on gear-scaled encoder-unit command
// - low-pass or median filter, median 0..128 ms
// - low-pass constant 0..32767 ms, default 20, stopped
// - larger constant gives more command lag
// - complete flag after condition holds hold time
// - flags routable to outputs and visible monitor
// - threshold in 0.0001 revolution units
// - near flag uses own condition, same hold
// - complete condition selector 0..4, default 0
// - detection only in position mode while running
// - code 0: error below threshold only
// - code 1: also raw speed command zero
// - code 2: also filtered speed command zero
// - code 3: latch, clear on nonzero speed
// - code 4: multi-segment done and error small
// - completion threshold 0..32767, default 10
`default_nettype none
package pcf_pkg;
    localparam logic [7:0] PCF_ADDR_MEDIAN = 8'h00;
    localparam logic [7:0] PCF_ADDR_LOWPASS = 8'h04;
    localparam logic [7:0] PCF_ADDR_COMPCOND = 8'h08;
    localparam logic [7:0] PCF_ADDR_COMPTHR = 8'h0C;
    localparam logic [7:0] PCF_ADDR_NEARCOND = 8'h10;
    localparam logic [7:0] PCF_ADDR_NEARTHR = 8'h14;
    localparam logic [7:0] PCF_ADDR_HOLD = 8'h18;
    localparam logic [7:0] PCF_ADDR_DOSEL = 8'h1C;
    localparam logic [7:0] PCF_ADDR_FSEL = 8'h20;
    localparam logic [7:0] PCF_ADDR_STATUS = 8'h24;
    localparam logic [7:0] PCF_ADDR_ERR = 8'h28;
    localparam logic [7:0] PCF_ADDR_FOUT = 8'h2C;
    localparam logic [15:0] PCF_RST_MEDIAN = 16'h0000;
    localparam logic [15:0] PCF_RST_LOWPASS = 16'h0014;
    localparam logic [15:0] PCF_RST_COMPCOND = 16'h0000;
    localparam logic [15:0] PCF_RST_COMPTHR = 16'h000A;
    localparam logic [15:0] PCF_RST_NEARCOND = 16'h0000;
    localparam logic [15:0] PCF_RST_NEARTHR = 16'h0064;
    localparam logic [15:0] PCF_RST_HOLD = 16'h000A;
    localparam logic [15:0] PCF_MAX_MEDIAN = 16'h0080;
    localparam logic [15:0] PCF_MAX_TC = 16'h7FFF;
    localparam logic [15:0] PCF_MAX_COND = 16'h0004;
    localparam logic [15:0] PCF_MAX_NEARCOND = 16'h0003;
    localparam int PCF_CLK_HZ = 125000000;
    localparam int PCF_MS_TIME = 1;
    localparam int PCF_MS_CYCLES = PCF_CLK_HZ / 1000 * PCF_MS_TIME;
    localparam int PCF_MED_TAPS = 3;
    localparam int PCF_FIFO_DEPTH = 4;
endpackage : pcf_pkg
`default_nettype wire

// *** verilog/pcf_fifo.sv ***
// Purpose: small synchronous fifo for the position command stream
// Assumes: single clock, asynchronous active-low reset
// Notes: full and empty are exact; no write when full, no read when empty
`default_nettype none
module pcf_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, low
    input wire logic in_valid, // write request
    output logic in_ready, // room available
    input wire logic [WIDTH-1:0] in_data, // write word
    output logic out_valid, // word available
    input wire logic out_ready, // consumer takes word
    output logic [WIDTH-1:0] out_data // head word
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    // handshake terms
    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[rd_q];

    // storage, no reset needed for data
    always_ff @(posedge pclk)
    begin
        if (push)
            mem_q[wr_q] <= in_data;
    end

    // pointers and fill level
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
            if (pop)
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
            if (push && !pop)
                cnt_q <= cnt_q + (AW+1)'(1);
            else if (pop && !push)
                cnt_q <= cnt_q - (AW+1)'(1);
        end
    end
endmodule // pcf_fifo
`default_nettype wire

// *** verilog/pcf_top.sv ***
// Purpose: position command filter with positioning complete and near flags
// Assumes: command samples arrive gear-scaled in encoder units, one per ms tick at most
// Notes: filter runs once per ms tick; flags evaluated every clock, hold time counted in ms ticks
`default_nettype none
module pcf_top
    import pcf_pkg::*;
#(
    parameter int MS_CYCLES = PCF_MS_CYCLES,
    parameter int CW = 32
) (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, low
    input wire logic [7:0] paddr, // apb address
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic cmd_valid, // gear-scaled command valid
    output logic cmd_ready, // fifo room
    input wire logic [CW-1:0] cmd_data, // gear-scaled command, encoder units
    output logic filt_valid, // filtered command valid
    input wire logic filt_ready, // position loop accepts
    output logic [CW-1:0] filt_data, // filtered command
    input wire logic [CW-1:0] position_error_value, // signed position error
    input wire logic [CW-1:0] pos_mode_speed_cmd, // raw speed command
    input wire logic [CW-1:0] pos_mode_filtered_speed_cmd, // filtered speed command
    input wire logic pos_mode, // drive in position mode
    input wire logic running, // drive enabled and running
    input wire logic multiseg_done, // multi-segment sequence finished
    output logic complete_flag, // positioning complete
    output logic near_flag, // positioning near
    output logic [1:0] digital_output // routed output terminals
);
    typedef enum logic [1:0] {PCF_FSEL_LOWPASS, PCF_FSEL_MEDIAN} pcf_fsel_type;

    logic [15:0] median_filter_time_const_q;
    logic [15:0] lowpass_filter_time_const_q;
    logic [15:0] complete_output_condition_q;
    logic [15:0] complete_threshold_q;
    logic [15:0] near_output_condition_q;
    logic [15:0] near_threshold_q;
    logic [15:0] in_position_hold_time_q;
    logic [3:0] digital_output_function_select_q;
    pcf_fsel_type fsel_q;
    logic [31:0] ms_cnt_q;
    logic tick;
    logic stopped;
    logic wr_en;
    logic [31:0] rdata_d;
    logic [CW-1:0] err_abs;
    logic fifo_valid;
    logic fifo_pop;
    logic [CW-1:0] fifo_data;
    logic [CW-1:0] lp_q;
    logic [CW-1:0] med_q [PCF_MED_TAPS];
    logic [15:0] med_cnt_q;
    logic [CW-1:0] med_out;
    logic [CW-1:0] sel_out;
    logic filt_full_q;
    logic pop_q;
    logic comp_cond;
    logic comp_set;
    logic comp_latch_q;
    logic near_cond;
    logic [15:0] comp_hold_q;
    logic [15:0] near_hold_q;
    logic speed_zero;
    logic fspeed_zero;

    // millisecond time base
    assign tick = (ms_cnt_q == 32'(MS_CYCLES - 1));
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ms_cnt_q <= '0;
        else
            ms_cnt_q <= tick ? '0 : ms_cnt_q + 32'h00000001;
    end

    // apb slave: zero wait, unmapped reads zero and flag error
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign stopped = !running;
    assign pslverr = psel && penable && (paddr > PCF_ADDR_FOUT || paddr[1:0] != 2'b00);

    // filter constants writable only while stopped
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            median_filter_time_const_q <= PCF_RST_MEDIAN;
            lowpass_filter_time_const_q <= PCF_RST_LOWPASS;
            fsel_q <= PCF_FSEL_LOWPASS;
        end
        else if (wr_en && stopped)
        begin
            if (paddr == PCF_ADDR_MEDIAN && pwdata[15:0] <= PCF_MAX_MEDIAN)
                median_filter_time_const_q <= pwdata[15:0];
            if (paddr == PCF_ADDR_LOWPASS && pwdata[15:0] <= PCF_MAX_TC)
                lowpass_filter_time_const_q <= pwdata[15:0];
            if (paddr == PCF_ADDR_FSEL)
                fsel_q <= pwdata[0] ? PCF_FSEL_MEDIAN : PCF_FSEL_LOWPASS;
        end
    end

    // in-position settings writable any time, out of range ignored
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            complete_output_condition_q <= PCF_RST_COMPCOND;
            complete_threshold_q <= PCF_RST_COMPTHR;
            near_output_condition_q <= PCF_RST_NEARCOND;
            near_threshold_q <= PCF_RST_NEARTHR;
            in_position_hold_time_q <= PCF_RST_HOLD;
            digital_output_function_select_q <= 4'h0;
        end
        else if (wr_en)
        begin
            if (paddr == PCF_ADDR_COMPCOND && pwdata[15:0] <= PCF_MAX_COND)
                complete_output_condition_q <= pwdata[15:0];
            if (paddr == PCF_ADDR_COMPTHR && pwdata[15:0] <= PCF_MAX_TC)
                complete_threshold_q <= pwdata[15:0];
            if (paddr == PCF_ADDR_NEARCOND && pwdata[15:0] <= PCF_MAX_NEARCOND)
                near_output_condition_q <= pwdata[15:0];
            if (paddr == PCF_ADDR_NEARTHR && pwdata[15:0] <= PCF_MAX_TC)
                near_threshold_q <= pwdata[15:0];
            if (paddr == PCF_ADDR_HOLD)
                in_position_hold_time_q <= pwdata[15:0];
            if (paddr == PCF_ADDR_DOSEL)
                digital_output_function_select_q <= pwdata[3:0];
        end
    end

    // read mux
    always_comb
    begin
        rdata_d = 32'h00000000;
        case (paddr)
            PCF_ADDR_MEDIAN: rdata_d = {16'h0000, median_filter_time_const_q};
            PCF_ADDR_LOWPASS: rdata_d = {16'h0000, lowpass_filter_time_const_q};
            PCF_ADDR_COMPCOND: rdata_d = {16'h0000, complete_output_condition_q};
            PCF_ADDR_COMPTHR: rdata_d = {16'h0000, complete_threshold_q};
            PCF_ADDR_NEARCOND: rdata_d = {16'h0000, near_output_condition_q};
            PCF_ADDR_NEARTHR: rdata_d = {16'h0000, near_threshold_q};
            PCF_ADDR_HOLD: rdata_d = {16'h0000, in_position_hold_time_q};
            PCF_ADDR_DOSEL: rdata_d = {28'h0000000, digital_output_function_select_q};
            PCF_ADDR_FSEL: rdata_d = {31'h00000000, fsel_q == PCF_FSEL_MEDIAN};
            PCF_ADDR_STATUS: rdata_d = {28'h0000000, digital_output, near_flag, complete_flag};
            PCF_ADDR_ERR: rdata_d = 32'(err_abs);
            PCF_ADDR_FOUT: rdata_d = 32'(filt_data);
            default: rdata_d = 32'h00000000;
        endcase
    end
    assign prdata = rdata_d;

    // command fifo in the data path; back-pressure reaches the source
    pcf_fifo #(
        .WIDTH(CW),
        .DEPTH(PCF_FIFO_DEPTH)
    ) u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(cmd_valid),
        .in_ready(cmd_ready),
        .in_data(cmd_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );
    // one sample per ms, and only while output slot is free
    assign fifo_pop = tick && fifo_valid && (!filt_full_q || filt_ready);

    // first-order low-pass: y += (x - y) / (tc + 1)
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            lp_q <= '0;
        else if (fifo_pop)
        begin
            if (lowpass_filter_time_const_q == 16'h0000)
                lp_q <= fifo_data;
            else
                lp_q <= CW'($signed(lp_q) + ($signed(fifo_data) - $signed(lp_q))
                        / $signed({1'b0, lowpass_filter_time_const_q} + 17'h00001));
        end
    end

    // median over three samples, older taps shifted every median time constant plus one samples
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            med_cnt_q <= '0;
            for (int i = 0; i < PCF_MED_TAPS; i++)
                med_q[i] <= '0;
        end
        else if (fifo_pop)
        begin
            med_cnt_q <= (med_cnt_q >= median_filter_time_const_q) ? '0 : med_cnt_q + 16'h0001;
            med_q[0] <= fifo_data;
            if (med_cnt_q >= median_filter_time_const_q)
            begin
                med_q[1] <= med_q[0]; // wider spacing gives more lag
                med_q[2] <= med_q[1];
            end
        end
    end

    // middle of three
    always_comb
    begin
        med_out = med_q[0];
        if (($signed(med_q[0]) >= $signed(med_q[1])) != ($signed(med_q[0]) >= $signed(med_q[2])))
            med_out = med_q[0];
        else if (($signed(med_q[1]) >= $signed(med_q[0])) != ($signed(med_q[1]) >= $signed(med_q[2])))
            med_out = med_q[1];
        else
            med_out = med_q[2];
    end

    // choose filter, bypass on zero constant
    always_comb
    begin
        case (fsel_q)
            PCF_FSEL_MEDIAN: sel_out = (median_filter_time_const_q == 16'h0000) ? med_q[0] : med_out;
            default: sel_out = lp_q;
        endcase
    end

    // output register for the filtered command
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            filt_full_q <= 1'b0;
        else if (pop_q)
            filt_full_q <= 1'b1;
        else if (filt_ready)
            filt_full_q <= 1'b0;
    end
    assign filt_valid = filt_full_q;
    // load once the filter holds the popped sample
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pop_q <= 1'b0;
            filt_data <= '0;
        end
        else
        begin
            pop_q <= fifo_pop;
            if (pop_q)
                filt_data <= sel_out;
        end
    end

    // absolute error, threshold taken in 0.0001 rev units
    assign err_abs = position_error_value[CW-1] ? CW'(-$signed(position_error_value)) : position_error_value;
    assign speed_zero = (pos_mode_speed_cmd == '0);
    assign fspeed_zero = (pos_mode_filtered_speed_cmd == '0);

    // completion condition per selector
    always_comb
    begin
        comp_set = err_abs < CW'(complete_threshold_q);
        case (complete_output_condition_q[2:0])
            3'h0: comp_cond = comp_set;
            3'h1: comp_cond = comp_set && speed_zero;
            3'h2: comp_cond = comp_set && fspeed_zero;
            3'h3: comp_cond = (comp_set && speed_zero) || (comp_latch_q && speed_zero);
            3'h4: comp_cond = comp_set && multiseg_done;
            default: comp_cond = 1'b0;
        endcase
        comp_cond = comp_cond && pos_mode && running;
    end

    // near condition per selector, same speed qualifiers
    always_comb
    begin
        case (near_output_condition_q[1:0])
            2'h1: near_cond = err_abs < CW'(near_threshold_q) && speed_zero;
            2'h2: near_cond = err_abs < CW'(near_threshold_q) && fspeed_zero;
            2'h3: near_cond = err_abs < CW'(near_threshold_q) && speed_zero;
            default: near_cond = err_abs < CW'(near_threshold_q);
        endcase
        near_cond = near_cond && pos_mode && running;
    end

    // code 3 holds once set until speed command nonzero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            comp_latch_q <= 1'b0;
        else
            comp_latch_q <= complete_flag && complete_output_condition_q == 16'h0003;
    end

    // hold-time counters tick in ms, restart when condition drops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            comp_hold_q <= '0;
            near_hold_q <= '0;
        end
        else
        begin
            if (!comp_cond)
                comp_hold_q <= '0;
            else if (tick && comp_hold_q < in_position_hold_time_q)
                comp_hold_q <= comp_hold_q + 16'h0001;
            if (!near_cond)
                near_hold_q <= '0;
            else if (tick && near_hold_q < in_position_hold_time_q)
                near_hold_q <= near_hold_q + 16'h0001;
        end
    end

    // flags registered; latched code 3 skips the hold once set
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            complete_flag <= 1'b0;
            near_flag <= 1'b0;
        end
        else
        begin
            complete_flag <= comp_cond && (comp_hold_q >= in_position_hold_time_q || comp_latch_q);
            near_flag <= near_cond && near_hold_q >= in_position_hold_time_q;
        end
    end

    // output terminal routing: bit0/1 select complete or near per terminal
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            digital_output <= 2'b00;
        else
        begin
            digital_output[0] <= digital_output_function_select_q[0] ? near_flag : complete_flag;
            digital_output[1] <= digital_output_function_select_q[1] ? near_flag : complete_flag;
        end
    end
endmodule // pcf_top
`default_nettype wire

// *** tb/pcf_chk.sv ***
// Purpose: port checker for pcf_top
// Assumes: zero-wait apb, registered flags
// Notes: bound to every pcf_top instance
`default_nettype none
module pcf_chk #(
    parameter int MS_CYCLES = 10
) (
    input wire logic pclk, // clock
    input wire logic presetn, // reset
    input wire logic [7:0] paddr, // apb
    input wire logic psel, // apb
    input wire logic penable, // apb
    input wire logic pwrite, // apb
    input wire logic [31:0] prdata, // apb
    input wire logic pready, // apb
    input wire logic pslverr, // apb
    input wire logic filt_valid, // out
    input wire logic filt_ready, // out
    input wire logic [31:0] filt_data, // out
    input wire logic pos_mode, // mode
    input wire logic running, // run
    input wire logic complete_flag // flag
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [9:0] run_q;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // cycles spent in position mode, saturating
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            run_q <= 10'h000;
        else if (!(running && pos_mode))
            run_q <= 10'h000;
        else if (run_q != 10'h3FF)
            run_q <= run_q + 10'h001;
    end
    sequence s_acc;
        psel && penable;
    endsequence
    sequence s_idle3;
        !(running && pos_mode) [*3];
    endsequence
    property p_ready; s_acc |-> pready; endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    property p_hi; s_acc ##0 paddr > 8'h2C |-> pslverr; endproperty
    a_hi: assert property (p_hi) else $error("no error on unmapped");
    property p_una; s_acc ##0 paddr[1:0] != 2'b00 |-> pslverr; endproperty
    a_una: assert property (p_una) else $error("no error on unaligned");
    property p_ok; s_acc ##0 (paddr <= 8'h2C && paddr[1:0] == 2'b00) |-> !pslverr; endproperty
    a_ok: assert property (p_ok) else $error("error on mapped");
    property p_zero; s_acc ##0 (!pwrite && paddr > 8'h2C) |-> prdata == 32'h0; endproperty
    a_zero: assert property (p_zero) else $error("unmapped read nonzero");
    property p_stop; s_idle3 |-> !complete_flag; endproperty
    a_stop: assert property (p_stop) else $error("flag while stopped");
    property p_rise; $rose(complete_flag) |-> run_q >= MS_CYCLES; endproperty
    a_rise: assert property (p_rise) else $error("flag before hold");
    property p_hold; filt_valid && !filt_ready |=> filt_valid && $stable(filt_data); endproperty
    a_hold: assert property (p_hold) else $error("output dropped");
endmodule // pcf_chk
bind pcf_top pcf_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .filt_valid(filt_valid), .filt_ready(filt_ready), .filt_data(filt_data), .pos_mode(pos_mode),
    .running(running), .complete_flag(complete_flag));
`default_nettype wire

// *** tb/pcf_host.sv ***
// Purpose: host controller model feeding commands
// Assumes: words already gear-scaled
// Notes: idle data inverts so stale words never look valid
`default_nettype none
module pcf_host (
    input wire logic pclk, // clock
    input wire logic presetn, // reset
    input wire logic cmd_ready, // room
    output logic cmd_valid, // offer
    output logic [31:0] cmd_data // word
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] q[$];
    task push(input logic [31:0] v);
        q.push_back(v);
    endtask
    // offer held until taken, encoder-unit words
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmd_valid <= 1'b0;
            cmd_data <= 32'h5A5A5A5A;
        end
        else if (cmd_valid && !cmd_ready)
            cmd_valid <= 1'b1;
        else if (q.size() > 0)
        begin
            cmd_valid <= 1'b1;
            cmd_data <= q.pop_front();
        end
        else
        begin
            cmd_valid <= 1'b0;
            cmd_data <= ~cmd_data;
        end
    end
endmodule // pcf_host
`default_nettype wire

// *** tb/pcf_top_tb.sv ***
// Purpose: testbench for pcf_top
// Assumes: ms tick shortened to 10 cycles
// Notes: apb tasks leave one idle cycle per transfer
`default_nettype none
module pcf_top_tb;
    import pcf_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, filt_ready, pos_mode, running, multiseg_done;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat, ofl, position_error_value, spd, fspd, cmd_data, filt_data;
    logic pready, pslverr, rerr, cmd_valid, cmd_ready, filt_valid, complete_flag, near_flag;
    logic [1:0] digital_output;
    int n_mismatch = 0;
    int checked = 0;
    always #4 pclk = ~pclk;
    pcf_top #(.MS_CYCLES(10)) i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_data(cmd_data),
        .filt_valid(filt_valid), .filt_ready(filt_ready), .filt_data(filt_data),
        .position_error_value(position_error_value), .pos_mode_speed_cmd(spd),
        .pos_mode_filtered_speed_cmd(fspd), .pos_mode(pos_mode), .running(running),
        .multiseg_done(multiseg_done), .complete_flag(complete_flag), .near_flag(near_flag),
        .digital_output(digital_output));
    pcf_host i_host (.pclk(pclk), .presetn(presetn), .cmd_ready(cmd_ready), .cmd_valid(cmd_valid),
        .cmd_data(cmd_data));
    task stop_test;
        $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task over;
        n_mismatch++;
        $display("[FAIL] t=%0t wait ran out", $time);
        stop_test;
    endtask
    // one apb transfer, then an idle cycle
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
            over;
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask
    task cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // bounded wait for the complete flag level
    task wait_flag(input logic e, input int lim);
        int n;
        n = 0;
        while (complete_flag !== e && n < lim)
        begin
            @(posedge pclk);
            n++;
        end
        if (n >= lim)
            over;
        chk({31'h0, complete_flag}, {31'h0, e});
    endtask
    task get_out;
        int n;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (filt_valid !== 1'b1 && n < 50);
        if (n >= 50)
            over;
        ofl = filt_data;
    endtask
    initial
    begin
        {presetn, psel, penable, pwrite, filt_ready, pos_mode, running, multiseg_done} = 8'h00;
        {paddr, pwdata, position_error_value, spd, fspd} = '0;
        cyc(6);
        presetn <= 1'b1;
        cyc(1);
        rdchk(PCF_ADDR_MEDIAN, 32'h0);
        rdchk(PCF_ADDR_LOWPASS, 32'h14);
        rdchk(PCF_ADDR_COMPCOND, 32'h0);
        rdchk(PCF_ADDR_COMPTHR, 32'hA);
        rdchk(8'h30, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        apb(1'b0, 8'h02, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        // out-of-range values leave the old setting
        wr(PCF_ADDR_MEDIAN, 32'h81);
        rdchk(PCF_ADDR_MEDIAN, 32'h0);
        wr(PCF_ADDR_MEDIAN, 32'h80);
        rdchk(PCF_ADDR_MEDIAN, 32'h80);
        wr(PCF_ADDR_LOWPASS, 32'h8000);
        rdchk(PCF_ADDR_LOWPASS, 32'h14);
        wr(PCF_ADDR_COMPTHR, 32'h8000);
        rdchk(PCF_ADDR_COMPTHR, 32'hA);
        for (int c = 0; c < 6; c++)
        begin
            wr(PCF_ADDR_COMPCOND, c);
            rdchk(PCF_ADDR_COMPCOND, (c < 5) ? c : 4);
        end
        running <= 1'b1;
        wr(PCF_ADDR_LOWPASS, 32'h0);
        rdchk(PCF_ADDR_LOWPASS, 32'h14);
        running <= 1'b0;
        wr(PCF_ADDR_LOWPASS, 32'h0);
        wr(PCF_ADDR_FSEL, 32'h0);
        // fill the fifo with the output stalled, then drain
        for (int i = 0; i < 6; i++)
            i_host.push(100 + i);
        cyc(80);
        chk({31'h0, cmd_ready}, 32'h0);
        filt_ready <= 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            get_out;
            chk(ofl, 100 + i);
        end
        wr(PCF_ADDR_LOWPASS, 32'h1);
        i_host.push(2000);
        get_out;
        chk({31'h0, ofl > 32'd105 && ofl < 32'd2000}, 32'h1);
        wr(PCF_ADDR_FSEL, 32'h1);
        wr(PCF_ADDR_MEDIAN, 32'h0);
        i_host.push(3000);
        get_out;
        chk(ofl, 3000);
        // flags: hold 3 ms, complete on terminal 0, near on 1
        wr(PCF_ADDR_HOLD, 32'h3);
        wr(PCF_ADDR_COMPCOND, 32'h0);
        wr(PCF_ADDR_DOSEL, 32'h2);
        position_error_value <= 32'd5;
        pos_mode <= 1'b1;
        running <= 1'b1;
        cyc(12);
        chk({31'h0, complete_flag}, 32'h0);
        wait_flag(1'b1, 60);
        cyc(3);
        chk({31'h0, near_flag}, 32'h1);
        chk({30'h0, digital_output}, 32'h3);
        position_error_value <= 32'd10;
        wait_flag(1'b0, 5);
        position_error_value <= 32'd5;
        cyc(15);
        position_error_value <= 32'd20;
        cyc(2);
        position_error_value <= 32'hFFFFFFFB;
        cyc(12);
        chk({31'h0, complete_flag}, 32'h0);
        wait_flag(1'b1, 60);
        // codes 1 and 2 each watch their own speed
        for (int c = 1; c < 3; c++)
        begin
            wr(PCF_ADDR_COMPCOND, c);
            spd <= (c == 1) ? 32'd7 : 32'd0;
            fspd <= (c == 2) ? 32'd7 : 32'd0;
            wait_flag(1'b0, 50);
            spd <= (c == 2) ? 32'd7 : 32'd0;
            fspd <= (c == 1) ? 32'd7 : 32'd0;
            wait_flag(1'b1, 60);
        end
        spd <= 32'd0;
        fspd <= 32'd0;
        wr(PCF_ADDR_COMPCOND, 32'h3);
        wait_flag(1'b1, 60);
        position_error_value <= 32'd500;
        cyc(20);
        chk({31'h0, complete_flag}, 32'h1);
        spd <= 32'd1;
        wait_flag(1'b0, 5);
        spd <= 32'd0;
        position_error_value <= 32'd5;
        wr(PCF_ADDR_COMPCOND, 32'h4);
        cyc(50);
        chk({31'h0, complete_flag}, 32'h0);
        multiseg_done <= 1'b1;
        wait_flag(1'b1, 60);
        running <= 1'b0;
        wait_flag(1'b0, 5);
        cyc(50);
        chk({31'h0, complete_flag}, 32'h0);
        stop_test;
    end
endmodule // pcf_top_tb
`default_nettype wire
